// ---- rtl/receive_dma_bus_master.sv ----
`timescale 1ns/1ps
// Overview of operation
// RULE1: a descriptor list whose last link returns to the first is followed forever.
// RULE2: one receive-done indication is raised per frame fully moved to host.
// RULE3: software gives each descriptor a buffer of at least 1518 bytes.
// RULE4: reception stays off after reset until the on control is written.
// RULE5: while on, only frames matching the programmed filter mode are accepted.
// RULE6: the off control during a frame takes effect after that frame ends.
// RULE7: a non-zero write to the list pointer starts descriptor processing from idle.
// RULE8: software ends a non-ring list with a zero next-descriptor link.
// RULE9: with a frame waiting, fragment address and length are fetched one by one.
// RULE10: pause stops receive DMA, continue restarts it; pointer and progress stay readable.
// RULE11: progress count reports bytes moved for the descriptor at the list pointer.
// RULE12: ten indication types; each reaches the interrupt line only when enabled.
// RULE13: the summary bit sets whenever any enabled indication is asserted.
// RULE14: the summary bit clears only by software writing one to it.
// RULE15: every descriptor fetch uses plain memory read.
// RULE16: transmit data reads pick read or read multiple from fragment, space, receive demand.
// RULE17: every descriptor write-back uses plain memory write.
// RULE18: receive data writes pick write or invalidate from fragment, fifo data, transmit demand.
// RULE19: invalidate writes need the config allow bit set and block bit clear.
// RULE20: one arbiter grants the master port to transmit or receive, one at a time.
// RULE21: normal transmit requests wait until free fifo space reaches the threshold.
// RULE22: both directions may raise urgent requests to avoid underrun or overrun.
// RULE23: an urgent request wins over a normal request of the other direction.
module receive_dma_bus_master
  import rx_dma_pkg::*;
#(
  parameter int BURST_MAX = 64,
  parameter int LINE_BYTES = 32,
  parameter int MAX_FRAGS = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // receive side of the mac
  input wire logic frame_start,
  input wire logic frame_active,
  input wire logic [FILT_W-1:0] frame_class,
  input wire rx_dma_pkg::rx_fifo_s rx_fifo,
  output logic frame_accept,
  output logic rx_enabled,
  output logic rx_frame_pop,
  // transmit dma requester
  input wire rx_dma_pkg::tx_stat_s tx_stat,
  output logic tx_done,
  // pci master port
  output rx_dma_pkg::bm_req_s bm_req,
  input wire logic bm_done,
  input wire logic [31:0] bm_rdata,
  // other indication events and interrupt line
  input wire logic [NUM_IND-2:0] ext_events,
  output logic intr
);
  import rx_dma_pkg::*;

  localparam logic [LEN_W-1:0] BURST_L = LEN_W'(BURST_MAX);
  localparam logic [LEN_W-1:0] LINE_L = LEN_W'(LINE_BYTES);
  localparam int IDX_W = $clog2(MAX_FRAGS + 1);

  if (BURST_MAX < LINE_BYTES || LINE_BYTES < 4 || MAX_FRAGS < 1 || BURST_MAX >= 65536) begin : g_chk
    $error("receive_dma_bus_master: unsupported parameters");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_RD_FRAG, ST_RD_LEN, ST_XFER, ST_WB, ST_RD_LINK
  } rx_state_e;

  rx_state_e state;
  logic [31:0] list_ptr;
  logic [31:0] frag_addr;
  logic [LEN_W-1:0] frag_left;
  logic [LEN_W-1:0] frame_left;
  logic [LEN_W-1:0] count;
  logic frag_last;
  logic [IDX_W-1:0] frag_idx;
  logic paused;
  logic off_pending;
  logic block_inv;
  logic [FILT_W-1:0] filt_mode;
  logic [IND_W-1:0] ind;
  logic [IND_W-1:0] mask;
  logic [LEN_W-1:0] thr;
  logic [CFG_W-1:0] cfg;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_got;
  logic w_got;

  function automatic logic [LEN_W-1:0] min_len(input logic [LEN_W-1:0] a,
                                               input logic [LEN_W-1:0] b);
    min_len = (a < b) ? a : b;
  endfunction : min_len

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge

  function automatic logic hit(input logic [7:0] a);
    hit = a == OFF_CTRL || a == OFF_FILT || a == OFF_LIST || a == OFF_PROG ||
          a == OFF_IND || a == OFF_MASK || a == OFF_THR || a == OFF_CFG;
  endfunction : hit

  // register write strobe and per-register selects
  logic do_wr;
  logic [31:0] wv;
  assign do_wr = aw_got && w_got && !bvalid;
  assign wv = merge(32'h0000_0000, w_data, w_strb);
  logic wr_ctrl;
  logic wr_list;
  logic wr_ind;
  assign wr_ctrl = do_wr && aw_addr == OFF_CTRL && w_strb[0];
  assign wr_list = do_wr && aw_addr == OFF_LIST;
  assign wr_ind = do_wr && aw_addr == OFF_IND;

  // receive request of the descriptor engine
  logic rx_done_ev;
  logic [LEN_W-1:0] chunk;
  logic [31:0] frag_base;
  logic rx_want;
  bm_req_s rx_r;
  assign rx_done_ev = bm_done && bm_req.valid && bm_req.rx_owner;
  assign chunk = min_len(min_len(frag_left, frame_left), BURST_L);
  assign frag_base = list_ptr + DESC_FRAG + FRAG_STRIDE * 32'(frag_idx);

  always_comb begin
    rx_r = '0;
    rx_r.valid = 1'b1;
    rx_r.rx_owner = 1'b1;
    rx_r.cmd = CMD_MR; // RULE15
    rx_r.len = WORD_BYTES;
    unique case (state)
      ST_RD_FRAG: rx_r.addr = frag_base; // RULE9
      ST_RD_LEN: rx_r.addr = frag_base + FRAG_LEN_OFS; // RULE9
      ST_XFER: begin
        rx_r.addr = frag_addr;
        rx_r.len = chunk;
        rx_r.cmd = CMD_MW;
        if (cfg[CFG_ALLOW] && !block_inv && chunk >= LINE_L && // RULE19
            rx_fifo.level >= LINE_L && !tx_stat.req) begin // RULE18
          rx_r.cmd = CMD_MWI;
        end
      end
      ST_WB: begin
        rx_r.addr = list_ptr + DESC_STAT;
        rx_r.cmd = CMD_MW; // RULE17
        rx_r.wdata = 32'(count);
        rx_r.wdata[STAT_DONE] = 1'b1;
      end
      ST_RD_LINK: rx_r.addr = list_ptr + DESC_LINK;
      ST_IDLE, ST_WAIT: rx_r.valid = 1'b0;
    endcase
    rx_want = rx_r.valid && !paused; // RULE10
  end

  // arbiter over the pci master port
  logic tx_ok;
  logic pick_rx;
  assign tx_ok = tx_stat.req && (tx_stat.urgent || tx_stat.fifo_free >= thr); // RULE21 RULE22
  assign pick_rx = rx_want && (rx_fifo.urgent || !tx_stat.urgent || !tx_ok); // RULE23

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bm_req <= '0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= bm_done && bm_req.valid && !bm_req.rx_owner;
      if (bm_req.valid) begin
        if (bm_done) begin
          bm_req.valid <= 1'b0;
        end
      end else if (pick_rx) begin // RULE20
        bm_req <= rx_r;
      end else if (tx_ok) begin // RULE20
        bm_req <= '0;
        bm_req.valid <= 1'b1;
        bm_req.addr <= tx_stat.addr;
        bm_req.len <= min_len(min_len(tx_stat.frag_left, tx_stat.fifo_free), BURST_L);
        bm_req.cmd <= (tx_stat.frag_left >= LINE_L && tx_stat.fifo_free >= LINE_L &&
                       !rx_want) ? CMD_MRM : CMD_MR; // RULE16
      end
    end
  end

  // descriptor engine and list pointer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      list_ptr <= '0;
      frag_addr <= '0;
      frag_left <= '0;
      frame_left <= '0;
      count <= '0;
      frag_last <= 1'b0;
      frag_idx <= '0;
      rx_frame_pop <= 1'b0;
    end else begin
      rx_frame_pop <= 1'b0;
      if (wr_list) begin
        list_ptr <= wv;
        count <= '0;
        frag_idx <= '0;
        if (state == ST_IDLE && wv != 32'h0000_0000) begin
          state <= ST_WAIT; // RULE7
        end
      end
      unique case (state)
        ST_IDLE: ;
        ST_WAIT: if (rx_fifo.frame_avail && !paused) begin
          frame_left <= rx_fifo.frame_len;
          frag_idx <= '0;
          count <= '0;
          state <= ST_RD_FRAG; // RULE9
        end
        ST_RD_FRAG: if (rx_done_ev) begin
          frag_addr <= bm_rdata;
          state <= ST_RD_LEN;
        end
        ST_RD_LEN: if (rx_done_ev) begin
          frag_left <= bm_rdata[LEN_W-1:0];
          frag_last <= bm_rdata[FRAG_LAST];
          state <= (bm_rdata[LEN_W-1:0] == '0) ? ST_WB : ST_XFER;
        end
        ST_XFER: if (rx_done_ev) begin
          frag_addr <= frag_addr + 32'(chunk);
          frag_left <= frag_left - chunk;
          frame_left <= frame_left - chunk;
          count <= count + chunk; // RULE11
          if (frame_left == chunk) begin
            state <= ST_WB;
          end else if (frag_left == chunk) begin
            if (frag_last || 32'(frag_idx) == MAX_FRAGS - 1) begin
              state <= ST_WB;
            end else begin
              frag_idx <= frag_idx + 1'b1;
              state <= ST_RD_FRAG;
            end
          end
        end
        ST_WB: if (rx_done_ev) begin
          rx_frame_pop <= 1'b1;
          state <= ST_RD_LINK;
        end
        ST_RD_LINK: if (rx_done_ev) begin
          list_ptr <= bm_rdata; // RULE1
          count <= '0;
          frag_idx <= '0;
          state <= (bm_rdata == 32'h0000_0000) ? ST_IDLE : ST_WAIT;
        end
      endcase
    end
  end

  // reception on/off, filter and pause control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_enabled <= 1'b0; // RULE4
      off_pending <= 1'b0;
      paused <= 1'b0;
      block_inv <= 1'b0; // RULE19
      frame_accept <= 1'b0;
    end else begin
      frame_accept <= frame_start && rx_enabled && |(frame_class & filt_mode); // RULE5
      if (off_pending && !frame_active) begin
        rx_enabled <= 1'b0; // RULE6
        off_pending <= 1'b0;
      end
      if (wr_ctrl) begin
        block_inv <= wv[CB_BLOCK];
        if (wv[CB_PAUSE]) begin
          paused <= 1'b1; // RULE10
        end
        if (wv[CB_CONT]) begin
          paused <= 1'b0; // RULE10
        end
        if (wv[CB_ON]) begin
          rx_enabled <= 1'b1; // RULE4
          off_pending <= 1'b0;
        end else if (wv[CB_OFF]) begin
          if (frame_active) begin
            off_pending <= 1'b1; // RULE6
          end else begin
            rx_enabled <= 1'b0;
          end
        end
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filt_mode <= '0;
      mask <= '0;
      thr <= '0;
      cfg <= '0;
    end else if (do_wr) begin
      if (aw_addr == OFF_FILT) begin
        filt_mode <= FILT_W'(merge(32'(filt_mode), w_data, w_strb));
      end
      if (aw_addr == OFF_MASK) begin
        mask <= IND_W'(merge(32'(mask), w_data, w_strb)) & ~IND_W'(1); // RULE12
      end
      if (aw_addr == OFF_THR) begin
        thr <= LEN_W'(merge(32'(thr), w_data, w_strb));
      end
      if (aw_addr == OFF_CFG) begin
        cfg <= CFG_W'(merge(32'(cfg), w_data, w_strb));
      end
    end
  end

  // indications: new events win over a write-one clear
  logic [IND_W-1:0] ev;
  logic [IND_W-1:0] clr;
  logic enabled_any;
  assign ev = {ext_events, rx_done_ev && state == ST_WB, 1'b0}; // RULE2
  assign clr = wr_ind ? wv[IND_W-1:0] : '0;
  assign enabled_any = |(ind & mask);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ind <= '0;
      intr <= 1'b0;
    end else begin
      ind[IND_W-1:1] <= (ind[IND_W-1:1] & ~clr[IND_W-1:1]) | ev[IND_W-1:1];
      if (enabled_any) begin
        ind[IND_SUM] <= 1'b1; // RULE13
      end else if (clr[IND_SUM]) begin
        ind[IND_SUM] <= 1'b0; // RULE14
      end
      intr <= enabled_any; // RULE12
    end
  end

  // axi4-lite write channels
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_got <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_got <= 1'b1;
        wready <= 1'b0;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= hit(aw_addr) ? RESP_OKAY : RESP_DECERR;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // axi4-lite read channels
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    unique case (araddr)
      OFF_CTRL: begin
        rd_val[CB_BLOCK] = block_inv;
        rd_val[CB_RXON] = rx_enabled;
        rd_val[CB_PAUSED] = paused;
        rd_val[CB_ACTIVE] = state != ST_IDLE;
      end
      OFF_FILT: rd_val = 32'(filt_mode);
      OFF_LIST: rd_val = list_ptr; // RULE10
      OFF_PROG: rd_val = 32'(count); // RULE11
      OFF_IND: rd_val = 32'(ind);
      OFF_MASK: rd_val = 32'(mask);
      OFF_THR: rd_val = 32'(thr);
      OFF_CFG: rd_val = 32'(cfg);
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= hit(araddr) ? RESP_OKAY : RESP_DECERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : receive_dma_bus_master

// ---- pkg/rx_dma_pkg.sv ----
package rx_dma_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FILT = 8'h04;
  localparam logic [7:0] OFF_LIST = 8'h08;
  localparam logic [7:0] OFF_PROG = 8'h0C;
  localparam logic [7:0] OFF_IND = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_THR = 8'h18;
  localparam logic [7:0] OFF_CFG = 8'h1C;
  // dma_control bits
  localparam int CB_ON = 0;
  localparam int CB_OFF = 1;
  localparam int CB_PAUSE = 2;
  localparam int CB_CONT = 3;
  localparam int CB_BLOCK = 4;
  localparam int CB_RXON = 5;
  localparam int CB_PAUSED = 6;
  localparam int CB_ACTIVE = 7;
  // config_command_word bit that allows invalidate writes
  localparam int CFG_ALLOW = 4;
  localparam int CFG_W = 16;
  // interrupt indications: bit 0 summary, bits 10:1 the ten types
  localparam int NUM_IND = 10;
  localparam int IND_W = NUM_IND + 1;
  localparam int IND_SUM = 0;
  localparam int IND_RXDONE = 1;
  localparam int FILT_W = 4;
  localparam int LEN_W = 16;
  // descriptor layout, byte offsets from the descriptor base
  localparam logic [31:0] DESC_LINK = 32'h0000_0000;
  localparam logic [31:0] DESC_STAT = 32'h0000_0004;
  localparam logic [31:0] DESC_FRAG = 32'h0000_0008;
  localparam logic [31:0] FRAG_STRIDE = 32'h0000_0008;
  localparam logic [31:0] FRAG_LEN_OFS = 32'h0000_0004;
  localparam logic [LEN_W-1:0] WORD_BYTES = 16'h0004;
  localparam int STAT_DONE = 31;
  localparam int FRAG_LAST = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // pci memory command codes
  typedef enum logic [3:0] {
    CMD_MR = 4'h6,
    CMD_MW = 4'h7,
    CMD_MRM = 4'hC,
    CMD_MWI = 4'hF
  } pci_cmd_e;
  typedef struct packed {
    logic valid;
    logic rx_owner;
    pci_cmd_e cmd;
    logic [31:0] addr;
    logic [LEN_W-1:0] len;
    logic [31:0] wdata;
  } bm_req_s;
  typedef struct packed {
    logic req;
    logic urgent;
    logic [31:0] addr;
    logic [LEN_W-1:0] frag_left;
    logic [LEN_W-1:0] fifo_free;
  } tx_stat_s;
  typedef struct packed {
    logic frame_avail;
    logic [LEN_W-1:0] frame_len;
    logic [LEN_W-1:0] level;
    logic urgent;
  } rx_fifo_s;
endpackage : rx_dma_pkg

// ---- test/rx_dma_chk.sv ----
`timescale 1ns/1ps
module rx_dma_chk
  import rx_dma_pkg::*;
#(
  parameter int BURST_MAX = 64
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // receive side
  input wire logic frame_start,
  input wire logic frame_active,
  input wire logic [FILT_W-1:0] frame_class,
  input wire logic frame_accept,
  input wire logic rx_enabled,
  input wire logic rx_frame_pop,
  // transmit requester and master port
  input wire rx_dma_pkg::tx_stat_s tx_stat,
  input wire logic tx_done,
  input wire rx_dma_pkg::bm_req_s bm_req,
  input wire logic bm_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_reset_quiet: assert property ($fell(rst) |-> !rx_enabled && !bm_req.valid)
    else $error("reception or master request active after reset");
  chk_accept_cause: assert property (frame_accept |->
    $past(frame_start) && $past(rx_enabled) && $past(frame_class) != 4'h0)
    else $error("frame accepted without start, enable or class");
  chk_off_waits: assert property (rx_enabled && frame_active |=> rx_enabled)
    else $error("reception stopped during a frame");
  chk_req_holds: assert property (bm_req.valid && !bm_done |=> bm_req.valid && $stable(bm_req))
    else $error("master request changed before completion");
  chk_rx_cmd: assert property (bm_req.valid && bm_req.rx_owner |->
    bm_req.cmd inside {CMD_MR, CMD_MW, CMD_MWI})
    else $error("receive side used a wrong command");
  chk_tx_cmd: assert property (bm_req.valid && !bm_req.rx_owner |->
    bm_req.cmd inside {CMD_MR, CMD_MRM})
    else $error("transmit side used a wrong command");
  chk_tx_len: assert property ($rose(bm_req.valid) && !bm_req.rx_owner |->
    $past(tx_stat.req) && bm_req.len <= $past(tx_stat.fifo_free) && bm_req.len <= BURST_MAX)
    else $error("transmit burst exceeds free space or limit");
  chk_invalidate_gate: assert property ($rose(bm_req.valid) && bm_req.cmd == CMD_MWI |->
    !$past(tx_stat.req) && bm_req.len >= 16'h0020)
    else $error("invalidate write under wrong conditions");
  chk_pop_after_wb: assert property (rx_frame_pop |->
    $past(bm_done) && $past(bm_req.rx_owner) && $past(bm_req.cmd) == CMD_MW)
    else $error("frame pop without write-back completion");
  chk_tx_done_src: assert property (tx_done |->
    $past(bm_done) && $past(bm_req.valid) && !$past(bm_req.rx_owner))
    else $error("transmit done without transmit completion");
endmodule : rx_dma_chk

bind receive_dma_bus_master rx_dma_chk #(.BURST_MAX(BURST_MAX)) chk (
  .sys_clk(sys_clk), .rst(rst), .frame_start(frame_start), .frame_active(frame_active),
  .frame_class(frame_class), .frame_accept(frame_accept), .rx_enabled(rx_enabled),
  .rx_frame_pop(rx_frame_pop), .tx_stat(tx_stat), .tx_done(tx_done), .bm_req(bm_req),
  .bm_done(bm_done)
);

// ---- test/host_mem_model.sv ----
`timescale 1ns/1ps
module host_mem_model
  import rx_dma_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // master port
  input wire rx_dma_pkg::bm_req_s bm_req,
  input wire logic [3:0] wait_cycles,
  output logic bm_done,
  output logic [31:0] bm_rdata
);
  logic [31:0] words [0:255];
  logic [3:0] cnt;
  // read data is only meaningful with done; it toggles while idle or just after done, and holds during the wait
  // plain always: the bench preloads descriptor words
  always @(posedge sys_clk) begin
    if (rst || !bm_req.valid || bm_done) begin
      cnt <= 4'h0;
      bm_done <= 1'b0;
      bm_rdata <= rst ? 32'h0 : ~bm_rdata;
    end else if (cnt >= wait_cycles) begin
      bm_done <= 1'b1;
      if (bm_req.cmd == CMD_MW || bm_req.cmd == CMD_MWI) begin
        words[bm_req.addr[9:2]] <= bm_req.wdata;
      end else begin
        bm_rdata <= words[bm_req.addr[9:2]];
      end
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : host_mem_model

// ---- test/receive_dma_bus_master_test.sv ----
`timescale 1ns/1ps
module receive_dma_bus_master_test;
  import rx_dma_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic frame_start = 1'b0, frame_active = 1'b0, tx_seen = 1'b0, mwi_seen = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, frame_accept, rx_enabled, rx_frame_pop;
  logic tx_done, intr, bm_done;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, bm_rdata;
  logic [3:0] wstrb = 4'hF, frame_class = 4'h0, mem_wait = 4'h0;
  logic [1:0] bresp, rresp, rd_resp;
  logic [8:0] ext_events = 9'h000;
  rx_fifo_s rx_fifo = '0;
  tx_stat_s tx_stat = '0;
  bm_req_s bm_req;
  pci_cmd_e tx_cmd;
  int fail_count = 0, check_count = 0, pops = 0, txd = 0;

  always #20 sys_clk = ~sys_clk;

  receive_dma_bus_master dut (.sys_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .frame_start, .frame_active, .frame_class, .rx_fifo, .frame_accept,
    .rx_enabled, .rx_frame_pop, .tx_stat, .tx_done, .bm_req, .bm_done, .bm_rdata,
    .ext_events, .intr);
  host_mem_model mem (.sys_clk, .rst, .bm_req, .wait_cycles(mem_wait), .bm_done, .bm_rdata);

  always @(posedge sys_clk) begin
    if (rx_frame_pop) pops <= pops + 1;
    if (tx_done) txd <= txd + 1;
    if (bm_req.valid && !bm_req.rx_owner) begin
      tx_seen <= 1'b1;
      tx_cmd <= bm_req.cmd;
    end
    if (bm_req.valid && bm_req.cmd == CMD_MWI) mwi_seen <= 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic hang();
    fail_count++;
    $display("wrong value at %0t: wait ran out", $time);
    finish_test();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    repeat (40) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) return;
    end
    hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    araddr <= a;
    arvalid <= 1'b1;
    repeat (40) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd_resp = rresp;
        check(rdata, exp);
        return;
      end
    end
    hang();
  endtask : rd

  task automatic frame(input logic [3:0] cls, input logic exp);
    frame_start <= 1'b1;
    frame_class <= cls;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    @(posedge sys_clk);
    check(32'(frame_accept), 32'(exp));
  endtask : frame

  task automatic wait_count(input logic tx, input int n);
    repeat (3000) begin
      @(posedge sys_clk);
      if ((tx ? txd : pops) >= n) return;
    end
    hang();
  endtask : wait_count

  initial begin
    mem.words[16] = 32'h0000_0040;
    mem.words[18] = 32'h0000_0200;
    mem.words[19] = 32'h8000_05EE;
    mem.words[32] = 32'h0000_0000;
    mem.words[34] = 32'h0000_0280;
    mem.words[35] = 32'h8000_05EE;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(OFF_CTRL, 32'h0);
    rd(8'h20, 32'h0);
    check(32'(rd_resp), 32'h3);
    wr(OFF_FILT, 32'h1);
    frame(4'h1, 1'b0);
    wr(OFF_CTRL, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_FILT, 32'(1 << m));
      for (int c = 0; c < 4; c++) frame(4'(1 << c), c == m);
    end
    // off request while mid-frame
    frame_active <= 1'b1;
    wr(OFF_CTRL, 32'h2);
    repeat (4) @(posedge sys_clk);
    check(32'(rx_enabled), 32'h1);
    frame_active <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(32'(rx_enabled), 32'h0);
    wr(OFF_CTRL, 32'h1);
    // transmit requester: threshold, then urgent
    wr(OFF_THR, 32'h20);
    tx_stat <= '{1'b1, 1'b0, 32'h0000_0300, 16'h0040, 16'h0010};
    repeat (20) @(posedge sys_clk);
    check(32'(tx_seen), 32'h0);
    tx_stat.fifo_free <= 16'h0040;
    wait_count(1'b1, 1);
    check(32'(tx_cmd), 32'(CMD_MRM));
    tx_stat.req <= 1'b0;
    repeat (10) @(posedge sys_clk);
    tx_stat <= '{1'b1, 1'b1, 32'h0000_0300, 16'h0040, 16'h0010};
    wait_count(1'b1, txd + 1);
    check(32'(tx_cmd), 32'(CMD_MR));
    tx_stat.req <= 1'b0;
    repeat (10) @(posedge sys_clk);
    // receive ring, first held by pause
    mem_wait <= 4'h3;
    wr(OFF_MASK, 32'h2);
    wr(OFF_CTRL, 32'h4);
    wr(OFF_LIST, 32'h40);
    rx_fifo <= '{1'b1, 16'h0008, 16'h0008, 1'b0};
    repeat (10) @(posedge sys_clk);
    check(32'(bm_req.valid), 32'h0);
    rd(OFF_LIST, 32'h40);
    rd(OFF_PROG, 32'h0);
    wr(OFF_CTRL, 32'h8);
    wait_count(1'b0, 2);
    rx_fifo.frame_avail <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(mem.words[17], 32'h8000_0008);
    check(32'(intr), 32'h1);
    rd(OFF_IND, 32'h3);
    wr(OFF_IND, 32'h3);
    rd(OFF_IND, 32'h1);
    wr(OFF_IND, 32'h1);
    rd(OFF_IND, 32'h0);
    check(32'(intr), 32'h0);
    // masked indication, then enabled
    ext_events <= 9'h001;
    @(posedge sys_clk);
    ext_events <= 9'h000;
    repeat (4) @(posedge sys_clk);
    check(32'(intr), 32'h0);
    rd(OFF_IND, 32'h4);
    wr(OFF_MASK, 32'h4);
    repeat (4) @(posedge sys_clk);
    check(32'(intr), 32'h1);
    rd(OFF_IND, 32'h5);
    wr(OFF_IND, 32'h5);
    rd(OFF_IND, 32'h1);
    wr(OFF_IND, 32'h1);
    rd(OFF_IND, 32'h0);
    // invalidate write into a list that ends with a zero link
    wr(OFF_CFG, 32'h10);
    wr(OFF_LIST, 32'h80);
    rx_fifo <= '{1'b1, 16'h0040, 16'h0040, 1'b0};
    wait_count(1'b0, pops + 1);
    rx_fifo.frame_avail <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check(32'(mwi_seen), 32'h1);
    check(mem.words[33], 32'h8000_0040);
    rd(OFF_CTRL, 32'h20);
    finish_test();
  end
endmodule : receive_dma_bus_master_test
